// File: verilog/wsb_core.sv
// wsb_core: auto wake/sleep, boot-done status, boot pulse and temperature result
// assumes odr_tick_i, events and boot strobes come from logic on clk_sys_i
//
// What this block does
// - set change flag on mode switch, except a wake forced by a zero count
// - sleep after programmed idle data periods
// - sleep applies sleep power and rate
// - event wakes device with wake settings
// - mode status shows transition direction
// - reading mode status clears change flag
// - need count>=1; flag needs enable bit
// - boot flag set; cleared by resets only
// - register access refused before boot completes
// - select low: short pulse on routed pin
// - select high: long low open-drain pulse
// - first short boot pulse active high after POR
// - soft reset keeps pin polarity, driver, route
// - temperature is 8-bit two's complement
// - temperature refreshed every data period
`timescale 1ns/10ps
module wsb_core
#(
    parameter int unsigned SHORT_BOOT_PULSE_US = 1,      // short_boot_pulse_width
    parameter int unsigned LONG_BOOT_PULSE_MS  = 1       // long_boot_pulse_width
)
(
    input  wire logic                     clk_sys_i,            // system clock
    input  wire logic                     rst_i,                // power-on reset
    input  wire logic                     soft_reset_i,         // soft reset pulse
    input  wire logic                     hibernate_exit_i,     // hibernate exit pulse
    input  wire logic                     boot_complete_i,      // boot finished pulse
    input  wire logic                     boot_select_pin_i,    // boot_signal_select pin
    input  wire logic                     odr_tick_i,           // one pulse per data period
    input  wire logic                     event_any_i,          // any configured event active
    input  wire logic [7:0]               temp_code_i,          // temperature sample, 00h at 25 C
    input  wire logic [15:0]              inactivity_period_count_i, // idle periods before sleep
    input  wire logic                     wake_sleep_event_enable_i, // change flag enable
    input  wire logic                     flex_mode_i,          // flexible performance select
    input  wire wsb_pkg::wsb_perf_type    wake_perf_i,          // wake settings
    input  wire wsb_pkg::wsb_perf_type    sleep_perf_i,         // sleep settings
    input  wire wsb_pkg::wsb_pin_cfg_type pin_cfg_i,            // event pin settings
    input  wire wsb_pkg::wsb_reg_req_type reg_req_i,            // register access
    output logic [7:0]                    reg_rdata_o,          // read data
    output logic                          reg_ack_o,            // access accepted
    output logic                          reg_nak_o,            // access refused
    output wsb_pkg::wsb_perf_type         active_perf_o,        // settings in force
    output logic                          asleep_o,             // 1 while sleeping
    output logic                          first_event_pin_o,    // pin level
    output logic                          first_event_pin_oe_o, // pin drive enable
    output logic                          second_event_pin_o,   // pin level
    output logic                          second_event_pin_oe_o // pin drive enable
);
    import wsb_pkg::*;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned SHORT_BOOT_CYC =
        (SHORT_BOOT_PULSE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LONG_BOOT_CYC  =
        (LONG_BOOT_PULSE_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic            bsel_meta_r;          // synchroniser stage one
    logic            bsel_sync_r;          // synchronised boot select
    logic            boot_done_flag_r;     // boot_done_flag
    logic            ws_change_flag_r;     // wake_sleep_change_flag
    logic            to_sleep_dir_r;       // last transition was into sleep
    wsb_mode_type    mode_r;               // wake or sleep
    logic [15:0]     idle_cnt_r;           // idle data periods counted
    logic [7:0]      temperature_result_r; // temperature_result
    wsb_pin_cfg_type pin_eff_r;            // pin settings governing boot pulse
    logic            boot_start_r;         // launch the boot pulse
    logic            long_mode_r;          // pulse uses long form
    logic            boot_busy;            // boot pulse in progress
    logic            auto_on;              // auto wake/sleep allowed
    logic            go_sleep;             // wake-to-sleep this cycle
    logic            go_wake;              // sleep-to-wake this cycle
    logic            mode_rd;              // accepted read of mode status
    logic [31:0]     pulse_len;            // pulse length chosen at start

    assign auto_on = (inactivity_period_count_i >= INACT_COUNT_ONE);
    assign go_sleep = auto_on && (mode_r == WSB_WAKE) && odr_tick_i && !event_any_i
                      && (idle_cnt_r + INACT_COUNT_ONE >= inactivity_period_count_i);
    assign go_wake  = (mode_r == WSB_SLEEP) && (event_any_i || !auto_on);
    assign mode_rd  = reg_req_i.rd && boot_done_flag_r && (reg_req_i.addr == MODE_STATUS_ADDR);
    assign pulse_len = bsel_sync_r ? LONG_BOOT_CYC : SHORT_BOOT_CYC;

    // ------------------------------------------------------------
    // boot select pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bsel_meta_r <= 1'b0;
            bsel_sync_r <= 1'b0;
        end
        else
        begin
            bsel_meta_r <= boot_select_pin_i;
            bsel_sync_r <= bsel_meta_r;
        end
    end

    // ------------------------------------------------------------
    // boot done flag; a completing boot wins over a reset strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            boot_done_flag_r <= 1'b0;
        else if (boot_complete_i)
            boot_done_flag_r <= 1'b1;
        else if (soft_reset_i || hibernate_exit_i)
            boot_done_flag_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // pin settings: writes only land after boot, so defaults rule
    // the first pulse after power-on or hibernate exit; frozen from launch to end of pulse
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            pin_eff_r <= '0;
        else if (hibernate_exit_i)
            pin_eff_r <= '0;
        else if (boot_done_flag_r && !boot_start_r && !boot_busy)
            pin_eff_r <= pin_cfg_i;              // soft reset leaves this alone
    end

    // ------------------------------------------------------------
    // boot pulse launch on boot completion
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            boot_start_r <= 1'b0;
            long_mode_r  <= 1'b0;
        end
        else
        begin
            boot_start_r <= boot_complete_i && !boot_done_flag_r;
            if (boot_complete_i && !boot_done_flag_r)
                long_mode_r <= bsel_sync_r;
        end
    end

    wsb_pulse_timer #(
        .CNT_W   (32)
    ) u_boot_pulse (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .start_i   (boot_start_r),
        .len_i     (pulse_len),
        .busy_o    (boot_busy)
    );

    // ------------------------------------------------------------
    // event pin drivers; open drain only drives the low level
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            first_event_pin_o     <= 1'b0;
            first_event_pin_oe_o  <= 1'b1;
            second_event_pin_o    <= 1'b0;
            second_event_pin_oe_o <= 1'b0;
        end
        else if (long_mode_r)
        begin
            // long form: second pin, active low, open drain
            first_event_pin_o     <= pin_eff_r.polarity;
            first_event_pin_oe_o  <= !pin_eff_r.open_drain;
            second_event_pin_o    <= 1'b0;
            second_event_pin_oe_o <= boot_busy;
        end
        else
        begin
            // short form: routed pin, programmed polarity and driver
            first_event_pin_o  <= pin_eff_r.polarity ^
                                  (boot_busy && !pin_eff_r.route_second);
            second_event_pin_o <= pin_eff_r.polarity ^
                                  (boot_busy && pin_eff_r.route_second);
            first_event_pin_oe_o  <= !pin_eff_r.open_drain ||
                (pin_eff_r.polarity ^ (boot_busy && !pin_eff_r.route_second)) == 1'b0;
            second_event_pin_oe_o <= !pin_eff_r.open_drain ||
                (pin_eff_r.polarity ^ (boot_busy && pin_eff_r.route_second)) == 1'b0;
        end
    end

    // ------------------------------------------------------------
    // wake/sleep mode machine
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_r         <= WSB_WAKE;
            to_sleep_dir_r <= 1'b0;
        end
        else
        begin
            case (mode_r)
                WSB_WAKE:
                begin
                    if (go_sleep)
                    begin
                        mode_r         <= WSB_SLEEP;
                        to_sleep_dir_r <= 1'b1;
                    end
                end
                WSB_SLEEP:
                begin
                    if (go_wake)
                    begin
                        mode_r         <= WSB_WAKE;
                        to_sleep_dir_r <= 1'b0;
                    end
                end
                default:
                    mode_r <= WSB_WAKE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // idle period counter; any event restarts the interval
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            idle_cnt_r <= INACT_COUNT_ZERO;
        else if (!auto_on || mode_r == WSB_SLEEP || event_any_i || go_sleep)
            idle_cnt_r <= INACT_COUNT_ZERO;
        else if (odr_tick_i)
            idle_cnt_r <= idle_cnt_r + INACT_COUNT_ONE;
    end

    // ------------------------------------------------------------
    // change flag: a transition in the read cycle still sets it
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            ws_change_flag_r <= 1'b0;
        else if ((go_sleep || (go_wake && auto_on)) && wake_sleep_event_enable_i)
            ws_change_flag_r <= 1'b1;
        else if (mode_rd || !wake_sleep_event_enable_i)
            ws_change_flag_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // applied power and rate set
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            active_perf_o <= '0;
            asleep_o      <= 1'b0;
        end
        else
        begin
            // unused half of the set is zeroed so the consumer sees one choice
            active_perf_o <= (mode_r == WSB_SLEEP) ? sleep_perf_i : wake_perf_i;
            if (flex_mode_i)
                active_perf_o.output_data_rate <= '0;
            else
            begin
                active_perf_o.decim <= '0;
                active_perf_o.idle  <= '0;
            end
            asleep_o <= (mode_r == WSB_SLEEP);
        end
    end

    // ------------------------------------------------------------
    // temperature result, raw two's complement code
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            temperature_result_r <= REG_ZERO;
        else if (odr_tick_i)
            temperature_result_r <= temp_code_i;
    end

    // ------------------------------------------------------------
    // register port; all registers are read only, writes just ack after boot
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= REG_ZERO;
            reg_ack_o   <= 1'b0;
            reg_nak_o   <= 1'b0;
        end
        else
        begin
            reg_ack_o <= (reg_req_i.rd || reg_req_i.wr) && boot_done_flag_r;
            reg_nak_o <= (reg_req_i.rd || reg_req_i.wr) && !boot_done_flag_r;
            reg_rdata_o <= REG_ZERO;
            if (reg_req_i.rd && boot_done_flag_r)
            begin
                if (reg_req_i.addr == EVENT_STATUS_ADDR)
                begin
                    reg_rdata_o[BOOT_DONE_BIT] <= boot_done_flag_r;
                    reg_rdata_o[WS_CHANGE_BIT] <= ws_change_flag_r;
                end
                else if (reg_req_i.addr == TEMP_RESULT_ADDR)
                    reg_rdata_o <= temperature_result_r;
                else if (reg_req_i.addr == MODE_STATUS_ADDR)
                begin
                    reg_rdata_o[MODE_ASLEEP_BIT] <= (mode_r == WSB_SLEEP);
                    reg_rdata_o[MODE_DIR_BIT]    <= to_sleep_dir_r;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_flag_on_switch: assert property (
        (go_sleep && wake_sleep_event_enable_i) |=> ws_change_flag_r)
        else $error("change flag not set on sleep entry");
    a_sleep_entry: assert property (
        go_sleep |=> mode_r == WSB_SLEEP ##1 asleep_o)
        else $error("sleep not entered after idle periods");
    a_sleep_settings: assert property (
        (mode_r == WSB_SLEEP && !flex_mode_i && $stable(sleep_perf_i))
        |=> active_perf_o.power == sleep_perf_i.power)
        else $error("sleep power not applied");
    a_wake_on_event: assert property (
        (mode_r == WSB_SLEEP && event_any_i) |=> mode_r == WSB_WAKE)
        else $error("event did not wake device");
    a_dir_report: assert property (
        $rose(mode_r == WSB_SLEEP) |-> to_sleep_dir_r)
        else $error("direction bit wrong after sleep entry");
    a_read_clears: assert property (
        (mode_rd && !go_sleep && !go_wake) |=> !ws_change_flag_r)
        else $error("mode status read did not clear flag");
    a_auto_gated: assert property (
        (!auto_on) |-> ##1 (mode_r == WSB_WAKE)[*2])
        else $error("auto wake/sleep active with zero count");
    a_boot_sticky: assert property (
        (boot_done_flag_r && !soft_reset_i && !hibernate_exit_i) |=> boot_done_flag_r)
        else $error("boot flag dropped without reset");
    a_refuse_early: assert property (
        ((reg_req_i.rd || reg_req_i.wr) && !boot_done_flag_r) |=> reg_nak_o && !reg_ack_o)
        else $error("access accepted before boot");
    a_long_pulse: assert property (
        (long_mode_r && boot_busy) |=> (!second_event_pin_o && second_event_pin_oe_o))
        else $error("long boot pulse not driven low");
    a_temp_refresh: assert property (
        odr_tick_i |=> temperature_result_r == $past(temp_code_i))
        else $error("temperature not refreshed on tick");

endmodule // wsb_core

// File: verilog/wsb_pkg.sv
// wsb_pkg: constants, types and timing for the wake/sleep and boot status block
// assumes a single 125 MHz system clock and an external serial-port decoder
package wsb_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 8;       // 125 MHz system clock
    localparam int unsigned NS_PER_US      = 1000;    // unit conversion
    localparam int unsigned NS_PER_MS      = 1000000; // unit conversion

    // ------------------------------------------------------------
    // register map (byte offsets on the serial port)
    // ------------------------------------------------------------
    localparam logic [7:0] EVENT_STATUS_ADDR   = 8'h00; // event_status, read only
    localparam logic [7:0] TEMP_RESULT_ADDR    = 8'h01; // temperature_result, read only
    localparam logic [7:0] MODE_STATUS_ADDR    = 8'h14; // operating_mode_status, read only

    // field positions
    localparam int unsigned BOOT_DONE_BIT      = 0;     // boot_done_flag
    localparam int unsigned WS_CHANGE_BIT      = 1;     // wake_sleep_change_flag
    localparam int unsigned MODE_ASLEEP_BIT    = 0;     // current mode, 1 = sleep
    localparam int unsigned MODE_DIR_BIT       = 1;     // last transition, 1 = into sleep

    // reset values and misc constants
    localparam logic [7:0]  REG_ZERO           = 8'h00;
    localparam logic [15:0] INACT_COUNT_ZERO   = 16'h0000;
    localparam logic [15:0] INACT_COUNT_ONE    = 16'h0001;
    localparam logic [1:0]  PIN_DRIVE_IDLE     = 2'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic {
        WSB_WAKE,
        WSB_SLEEP
    } wsb_mode_type;

    // power / rate set applied in one mode
    typedef struct packed {
        logic [1:0] power;   // power setting code
        logic [3:0] output_data_rate;     // output_data_rate code
        logic [3:0] decim;   // flexible decimation
        logic [7:0] idle;    // flexible idle time
    } wsb_perf_type;

    // event pin configuration, survives soft reset
    typedef struct packed {
        logic polarity;      // event_pin_polarity, 1 = active low
        logic open_drain;    // event_pin_driver_type, 1 = open drain
        logic route_second;  // boot_pulse_route_bit, 1 = second_event_pin
    } wsb_pin_cfg_type;

    // register access from the serial-port decoder
    typedef struct packed {
        logic       rd;      // read strobe, one cycle
        logic       wr;      // write strobe, one cycle
        logic [7:0] addr;    // register offset
        logic [7:0] wdata;   // write data
    } wsb_reg_req_type;

endpackage

// File: verilog/wsb_pulse_timer.sv
// wsb_pulse_timer: one-shot pulse of a length given at start
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/10ps
module wsb_pulse_timer
#(
    parameter int unsigned CNT_W = 32                    // counter width
)
(
    input  wire logic             clk_sys_i,             // system clock
    input  wire logic             rst_i,                 // async reset, active high
    input  wire logic             start_i,               // launch pulse
    input  wire logic [CNT_W-1:0] len_i,                 // pulse length in cycles
    output logic                  busy_o                 // high for len_i cycles
);
    import wsb_pkg::*;

    logic [CNT_W-1:0] left_r;                            // cycles still to go

    // ------------------------------------------------------------
    // down counter; a new start restarts the pulse
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            left_r <= '0;
            busy_o <= 1'b0;
        end
        else if (start_i)
        begin
            left_r <= len_i;
            busy_o <= 1'b1;
        end
        else if (left_r > CNT_W'(1))
        begin
            left_r <= left_r - CNT_W'(1);
        end
        else
        begin
            // last cycle of the pulse
            left_r <= '0;
            busy_o <= 1'b0;
        end
    end

endmodule // wsb_pulse_timer

// File: testbench/wsb_host_model.sv
// wsb_host_model: serial-port host issuing byte reads
// assumes the device answers within four cycles
`timescale 1ns/10ps
module wsb_host_model
(
    input  wire logic             clk_sys_i, // system clock
    input  wire logic             ack_i,     // accepted
    input  wire logic             nak_i,     // refused
    input  wire logic [7:0]       rdata_i,   // read data
    output wsb_pkg::wsb_reg_req_type req_o   // request
);
    import wsb_pkg::*;
    // ------------------------------------------------
    // read cycle
    // ------------------------------------------------
    initial req_o = '0;
    // released address is inverted so a stale bus never matches
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic n);
        @(posedge clk_sys_i) req_o <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk_sys_i) req_o <= '{1'b0, 1'b0, ~a, 8'hff};
        repeat (4) @(negedge clk_sys_i) if (ack_i || nak_i) {n, d} = {nak_i, rdata_i};
    endtask
endmodule // wsb_host_model

// File: testbench/wsb_core_tb.sv
// wsb_core_tb: self-checking bench for wsb_core
// assumes wsb_host_model stands in for the host
`timescale 1ns/10ps
module wsb_core_tb;
    import wsb_pkg::*;
    // ------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------
    logic clk_sys_i = 0, rst_i = 1, soft_reset_i = 0, boot_complete_i = 0, odr_tick_i = 0;
    logic event_any_i = 0, wake_sleep_event_enable_i = 1, n, reg_ack_o, reg_nak_o, asleep_o;
    logic boot_select_pin_i = 0, flex_mode_i = 0;
    logic first_event_pin_o, first_event_pin_oe_o, second_event_pin_o, second_event_pin_oe_o;
    logic [7:0] temp_code_i = 8'h00, reg_rdata_o, d, w1, w2;
    logic [15:0] inactivity_period_count_i = 16'h0002; // two idle periods
    wsb_perf_type wake_perf_i = 18'h2a5c3, sleep_perf_i = 18'h15a3c, active_perf_o;
    wsb_pin_cfg_type pin_cfg_i = 3'h0;
    wsb_reg_req_type reg_req_i;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    wsb_core dut_u (.clk_sys_i, .rst_i, .soft_reset_i, .hibernate_exit_i(1'b0), .boot_complete_i,
        .boot_select_pin_i, .odr_tick_i, .event_any_i, .temp_code_i, .inactivity_period_count_i,
        .wake_sleep_event_enable_i, .flex_mode_i, .wake_perf_i, .sleep_perf_i, .pin_cfg_i,
        .reg_req_i, .reg_rdata_o, .reg_ack_o, .reg_nak_o, .active_perf_o, .asleep_o, .first_event_pin_o,
        .first_event_pin_oe_o, .second_event_pin_o, .second_event_pin_oe_o);
    wsb_host_model host_u (.clk_sys_i, .ack_i(reg_ack_o), .nak_i(reg_nak_o), .rdata_i(reg_rdata_o),
        .req_o(reg_req_i));
    task automatic chk(input logic [18:0] s, input logic [18:0] e);
        samples_checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard, whole run is well under this
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    // one data period, event level held only during the tick cycle
    task automatic tick(input logic ev);
        @(posedge clk_sys_i) {odr_tick_i, event_any_i} <= {1'b1, ev};
        @(posedge clk_sys_i) {odr_tick_i, event_any_i} <= 2'h0;
        repeat (3) @(posedge clk_sys_i);
    endtask
    // boot pulse widths seen on both pins; 1 us is 125 cycles
    task automatic boot_check(input logic [15:0] e);
        @(posedge clk_sys_i) boot_complete_i <= 1'b1;
        @(posedge clk_sys_i) boot_complete_i <= 1'b0;
        {w1, w2} = 16'h0000;
        repeat (200) @(negedge clk_sys_i) {w1, w2} = {w1 + first_event_pin_o,
            w2 + (second_event_pin_o & second_event_pin_oe_o)};
        chk({w1, w2}, e);
    endtask
    task automatic status_temp;
        host_u.rd(8'h00, d, n);
        chk(d[0], 1'b1);
        @(posedge clk_sys_i) temp_code_i <= 8'hf3;
        tick(1'b1);
        host_u.rd(8'h01, d, n);
        chk(d, 8'hf3);
    endtask
    task automatic sleep_wake;
        tick(1'b0);
        tick(1'b1);
        tick(1'b0);
        chk(asleep_o, 1'b0);
        tick(1'b0);
        chk({asleep_o, active_perf_o}, {1'b1, sleep_perf_i.power, sleep_perf_i.output_data_rate, 12'h000});
        host_u.rd(8'h00, d, n);
        chk(d[1], 1'b1);
        host_u.rd(8'h14, d, n);
        chk(d, 8'h03);
        host_u.rd(8'h00, d, n);
        chk(d[1], 1'b0);
        @(posedge clk_sys_i) event_any_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        chk({asleep_o, active_perf_o}, {1'b0, wake_perf_i.power, wake_perf_i.output_data_rate, 12'h000});
        event_any_i <= 1'b0;
        host_u.rd(8'h00, d, n);
        chk(d[1], 1'b1);
        host_u.rd(8'h14, d, n);
        chk(d, 8'h00);
    endtask
    // flexible timing while awake, then a zero count forces wake with no flag
    task automatic flex_and_off;
        @(posedge clk_sys_i) flex_mode_i <= 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk(active_perf_o, {wake_perf_i.power, 4'h0, wake_perf_i.decim, wake_perf_i.idle});
        @(posedge clk_sys_i) flex_mode_i <= 1'b0;
        tick(1'b0);
        tick(1'b0);
        chk(asleep_o, 1'b1);
        host_u.rd(8'h14, d, n);
        @(posedge clk_sys_i) inactivity_period_count_i <= 16'h0000;
        repeat (3) @(negedge clk_sys_i);
        chk(asleep_o, 1'b0);
        host_u.rd(8'h00, d, n);
        chk(d[1], 1'b0);
        @(posedge clk_sys_i) inactivity_period_count_i <= 16'h0002;
    endtask
    // active-low setting kept over soft reset; select high gives the long low pulse
    task automatic long_boot;
        @(posedge clk_sys_i) {pin_cfg_i, boot_select_pin_i} <= 4'h9;
        repeat (3) @(posedge clk_sys_i);
        soft_reset_i <= 1'b1;
        @(posedge clk_sys_i) {soft_reset_i, boot_complete_i} <= 2'h1;
        @(posedge clk_sys_i) boot_complete_i <= 1'b0;
        repeat (150) @(negedge clk_sys_i);
        chk({first_event_pin_o, second_event_pin_o, second_event_pin_oe_o}, 3'h5);
    endtask
    initial
    begin
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        host_u.rd(8'h00, d, n);
        chk(n, 1'b1);
        boot_check(16'h7d00);
        status_temp();
        sleep_wake();
        flex_and_off();
        // route to second pin, then cleared config must not be taken
        @(posedge clk_sys_i) pin_cfg_i <= 3'h1;
        @(posedge clk_sys_i) soft_reset_i <= 1'b1;
        @(posedge clk_sys_i) {soft_reset_i, pin_cfg_i} <= 4'h0;
        boot_check(16'h007d);
        long_boot();
        wrap_up();
    end
endmodule // wsb_core_tb
